// ---- hw/afpl_defs.svh ----
`ifndef AFPL_DEFS_SVH
`define AFPL_DEFS_SVH

// ****************************************
// Timing
// ****************************************
`define AFPL_CLK_MHZ        250
`define AFPL_STARTUP_MS     10
`define AFPL_DC_TIME_MS     420
`define AFPL_KHZ_PER_MHZ    1000

// ****************************************
// Register map (byte addresses)
// ****************************************
`define AFPL_OFF_CTRL       8'h00
`define AFPL_OFF_STATUS     8'h04

// CTRL fields
`define AFPL_CTRL_SHDN      0
`define AFPL_CTRL_CLR       1
`define AFPL_CTRL_RST       1'h0

// STATUS fields
`define AFPL_ST_OC          0
`define AFPL_ST_OT          1
`define AFPL_ST_DC          2
`define AFPL_ST_UV          3
`define AFPL_ST_OV          4
`define AFPL_ST_HIZ         5
`define AFPL_ST_RUN         6
`define AFPL_ST_LOWCUR      7
`define AFPL_ST_FAULT_N     8

// Synchroniser bit positions
`define AFPL_IN_OC          0
`define AFPL_IN_OT          1
`define AFPL_IN_UV          2
`define AFPL_IN_OV          3
`define AFPL_IN_SD_N        4
`define AFPL_IN_POS         5
`define AFPL_IN_NEG         7
`define AFPL_IN_W           9

`endif

// ---- hw/afpl_pkg.sv ----
package afpl_pkg;

  typedef enum logic [1:0] {
    AFPL_SHUT  = 2'b00,
    AFPL_START = 2'b01,
    AFPL_RUN   = 2'b10
  } afpl_state_e;

  typedef logic [1:0] afpl_resp_t;

  localparam afpl_resp_t AFPL_OKAY   = 2'h0;
  localparam afpl_resp_t AFPL_SLVERR = 2'h2;

endpackage

// ---- hw/afpl_dc_if.sv ----
`timescale 1ns/10ps
interface afpl_dc_if #(parameter int NCH = 2);
  logic           en;
  logic [NCH-1:0] pos;
  logic [NCH-1:0] neg;
  logic           hit;

  modport det (input en, input pos, input neg, output hit);
  modport ctl (output en, output pos, output neg, input hit);
endinterface

// ---- hw/afpl_sync.sv ----
`timescale 1ns/10ps
module afpl_sync #(
  parameter int W = 1
) (
  input  wire logic         sys_clk,
  input  wire logic         rstn,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_q;

  // First stage is read only by the second stage
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      meta_q <= '0;
      q      <= '0;
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end
endmodule

// ---- hw/afpl_dc_det.sv ----
`timescale 1ns/10ps
module afpl_dc_det #(
  parameter int NCH = 2,
  parameter int CYC = 105000000,
  parameter int CW  = $clog2(CYC + 1)
) (
  input  wire logic sys_clk,
  input  wire logic rstn,
  afpl_dc_if.det    dc
);
  logic [NCH-1:0] hit_ch;

  // ****************************************
  // Per-channel same-polarity run counter
  // ****************************************
  genvar g;
  generate
    for (g = 0; g < NCH; g++) begin : g_ch
      logic [CW-1:0] cnt_q, cnt_d;
      logic          pol_q, pol_d;

      always_comb begin
        pol_d = pol_q;
        cnt_d = '0;
        if (dc.en && (dc.pos[g] ^ dc.neg[g])) begin
          pol_d = dc.pos[g];
          if (pol_q != dc.pos[g] || cnt_q == '0)
            cnt_d = CW'(1);
          else if (cnt_q == CW'(CYC))
            cnt_d = cnt_q;
          else
            cnt_d = cnt_q + CW'(1);
        end
      end

      always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
          cnt_q <= '0;
          pol_q <= 1'b0;
        end else begin
          cnt_q <= cnt_d;
          pol_q <= pol_d;
        end
      end

      // Saturated and still same polarity: strictly longer than the limit [RL3]
      assign hit_ch[g] = (cnt_q == CW'(CYC)) && dc.en && (dc.pos[g] ^ dc.neg[g]) && (pol_q == dc.pos[g]);
    end
  endgenerate

  assign dc.hit = |hit_ch;
endmodule

// ---- hw/afpl_top.sv ----
// What this block does
// RL1: Overcurrent latches a fault, outputs go high impedance, fault output low.
// RL2: Die over 150 C shuts down, disables outputs, latched and reported low.
// RL3: Same-polarity duty above 60% for over 420 ms on either channel flags DC.
// RL4: DC fault latches, both outputs go high impedance, fault output low.
// RL5: Supply below 4.5 V holds outputs high impedance, no fault, self-recovers.
// RL6: Supply above 27 V holds outputs high impedance, no fault, self-recovers.
// RL7: Latched faults persist until shutdown input is low; low level clears them. Code also clears them on a CTRL clear-bit write.
// RL8: Fault output looped to shutdown input clears the latch automatically.
// RL9: Fault output low on any reportable error, otherwise high.
// RL10: Start-up lasts 10 ms before amplification begins.
// RL11: Host should hold shutdown low at power-up until inputs settle.
// RL12: System may drive mute from inverted fault output for high-impedance restarts.
// RL13: Shutdown low mutes outputs and enters low-current state; high runs normally.
// RL14: Once cleared and fault-free, fault output releases and start-up reruns.
`timescale 1ns/10ps
`include "afpl_defs.svh"
module afpl_top #(
  parameter int NCH         = 2,
  parameter int ADDR_W      = 8,
  parameter int STARTUP_CYC = `AFPL_STARTUP_MS * `AFPL_KHZ_PER_MHZ * `AFPL_CLK_MHZ,
  parameter int DC_CYC      = `AFPL_DC_TIME_MS * `AFPL_KHZ_PER_MHZ * `AFPL_CLK_MHZ
) (
  input  wire logic                 sys_clk,
  input  wire logic                 rstn,
  // Protection indications from the analog side
  input  wire logic                 overcurrent_det,
  input  wire logic                 overtemp_det,
  input  wire logic                 supply_under_det,
  input  wire logic                 supply_over_det,
  input  wire logic [NCH-1:0]       duty_over_pos,
  input  wire logic [NCH-1:0]       duty_over_neg,
  input  wire logic                 shutdown_in_n,
  // Power stage control
  output logic                      fault_flag_out_n,
  output logic                      outputs_hiz,
  output logic                      amp_run,
  output logic                      low_current,
  // AXI4-Lite slave
  input  wire logic [ADDR_W-1:0]    s_axi_awaddr,
  input  wire logic                 s_axi_awvalid,
  output logic                      s_axi_awready,
  input  wire logic [31:0]          s_axi_wdata,
  input  wire logic [3:0]           s_axi_wstrb,
  input  wire logic                 s_axi_wvalid,
  output logic                      s_axi_wready,
  output afpl_pkg::afpl_resp_t      s_axi_bresp,
  output logic                      s_axi_bvalid,
  input  wire logic                 s_axi_bready,
  input  wire logic [ADDR_W-1:0]    s_axi_araddr,
  input  wire logic                 s_axi_arvalid,
  output logic                      s_axi_arready,
  output logic [31:0]               s_axi_rdata,
  output afpl_pkg::afpl_resp_t      s_axi_rresp,
  output logic                      s_axi_rvalid,
  input  wire logic                 s_axi_rready
);
  import afpl_pkg::*;

  localparam int SCW = $clog2(STARTUP_CYC + 1);

  generate
    if (NCH != 2 || ADDR_W < 4 || ADDR_W > 8 || STARTUP_CYC < 1 || DC_CYC < 1) begin : g_bad
      $error("afpl_top: unsupported parameter values");
    end
  endgenerate

  // ****************************************
  // Input synchronisers
  // ****************************************
  logic [`AFPL_IN_W-1:0] raw;
  logic [`AFPL_IN_W-1:0] syn;

  assign raw = {duty_over_neg, duty_over_pos, shutdown_in_n,
                supply_over_det, supply_under_det, overtemp_det, overcurrent_det};

  afpl_sync #(
    .W (`AFPL_IN_W)
  ) u_sync (
    .sys_clk (sys_clk),
    .rstn    (rstn),
    .d       (raw),
    .q       (syn)
  );

  logic oc_evt;
  logic ot_evt;
  logic uv_lvl;
  logic ov_lvl;
  logic sd_low;

  assign oc_evt = syn[`AFPL_IN_OC];
  assign ot_evt = syn[`AFPL_IN_OT];
  assign uv_lvl = syn[`AFPL_IN_UV];
  assign ov_lvl = syn[`AFPL_IN_OV];
  // Reset value of the synchroniser reads as shutdown held low
  assign sd_low = !syn[`AFPL_IN_SD_N];

  // ****************************************
  // DC detection
  // ****************************************
  afpl_state_e st_q;
  afpl_state_e st_d;

  afpl_dc_if #(.NCH(NCH)) dc_bus ();

  // Duty is only meaningful while switching; idle time never accumulates
  assign dc_bus.en  = (st_q == AFPL_RUN);
  assign dc_bus.pos = syn[`AFPL_IN_POS +: NCH];
  assign dc_bus.neg = syn[`AFPL_IN_NEG +: NCH];

  afpl_dc_det #(
    .NCH (NCH),
    .CYC (DC_CYC)
  ) u_dc (
    .sys_clk (sys_clk),
    .rstn    (rstn),
    .dc      (dc_bus)
  );

  // ****************************************
  // Fault latches
  // ****************************************
  logic ctrl_shdn_q;
  logic ctrl_shdn_d;
  logic sw_clear;
  logic oc_q;
  logic oc_d;
  logic ot_q;
  logic ot_d;
  logic dc_q;
  logic dc_d;
  logic lat_clear;

  // A low shutdown level clears; a looped fault line does this by itself [RL7] [RL8]
  assign lat_clear = sd_low | sw_clear;

  always_comb begin
    // Set wins over clear, so a fault still present re-latches at once
    oc_d = oc_evt | (oc_q & !lat_clear);        // [RL1]
    ot_d = ot_evt | (ot_q & !lat_clear);        // [RL2]
    dc_d = dc_bus.hit | (dc_q & !lat_clear);    // [RL4]
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      oc_q <= 1'b0;
      ot_q <= 1'b0;
      dc_q <= 1'b0;
    end else begin
      oc_q <= oc_d;
      ot_q <= ot_d;
      dc_q <= dc_d;
    end
  end

  // ****************************************
  // Power stage sequencer
  // ****************************************
  logic [SCW-1:0] su_cnt_q;
  logic [SCW-1:0] su_cnt_d;
  logic           stop;
  logic           supply_bad;
  logic           hiz_d;
  logic           run_d;
  logic           lowcur_d;
  logic           fault_n_d;

  // Supply faults only gate the stage; they are never latched [RL5] [RL6]
  assign supply_bad = uv_lvl | ov_lvl;
  assign stop       = sd_low | ctrl_shdn_q | supply_bad | oc_d | ot_d | dc_d;

  always_comb begin
    st_d     = st_q;
    su_cnt_d = su_cnt_q;
    unique case (st_q)
      AFPL_SHUT: begin
        su_cnt_d = '0;
        if (!stop)
          st_d = AFPL_START;                     // [RL14]
      end
      AFPL_START: begin
        if (stop) begin
          st_d = AFPL_SHUT;
        end else if (su_cnt_q == SCW'(STARTUP_CYC - 1)) begin
          st_d = AFPL_RUN;                       // [RL10]
        end else begin
          su_cnt_d = su_cnt_q + SCW'(1);
        end
      end
      AFPL_RUN: begin
        if (stop)
          st_d = AFPL_SHUT;
      end
      default: begin
        st_d = AFPL_SHUT;
      end
    endcase
    hiz_d     = (st_d != AFPL_RUN);              // [RL1] [RL2] [RL4] [RL5] [RL6]
    run_d     = (st_d == AFPL_RUN);
    lowcur_d  = sd_low | ctrl_shdn_q;            // [RL13]
    fault_n_d = !(oc_d | ot_d | dc_d);           // [RL9]
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      st_q             <= AFPL_SHUT;
      su_cnt_q         <= '0;
      outputs_hiz      <= 1'b1;
      amp_run          <= 1'b0;
      low_current      <= 1'b1;
      fault_flag_out_n <= 1'b1;
    end else begin
      st_q             <= st_d;
      su_cnt_q         <= su_cnt_d;
      outputs_hiz      <= hiz_d;
      amp_run          <= run_d;
      low_current      <= lowcur_d;
      fault_flag_out_n <= fault_n_d;
    end
  end

  // ****************************************
  // AXI4-Lite write channel
  // ****************************************
  logic              aw_full_q;
  logic              aw_full_d;
  logic              w_full_q;
  logic              w_full_d;
  logic [ADDR_W-1:0] awaddr_q;
  logic [ADDR_W-1:0] awaddr_d;
  logic [31:0]       wdata_q;
  logic [31:0]       wdata_d;
  logic [3:0]        wstrb_q;
  logic [3:0]        wstrb_d;
  logic              wr_do;
  logic              wr_hit;
  logic              bvalid_d;
  afpl_resp_t        bresp_d;

  // Address and data are held separately so they may arrive in either order
  assign wr_do    = aw_full_q & w_full_q & !s_axi_bvalid;
  assign wr_hit   = (awaddr_q == ADDR_W'(`AFPL_OFF_CTRL)) || (awaddr_q == ADDR_W'(`AFPL_OFF_STATUS));
  assign sw_clear = wr_do && (awaddr_q == ADDR_W'(`AFPL_OFF_CTRL)) && wstrb_q[0] && wdata_q[`AFPL_CTRL_CLR];

  always_comb begin
    aw_full_d   = aw_full_q;
    w_full_d    = w_full_q;
    awaddr_d    = awaddr_q;
    wdata_d     = wdata_q;
    wstrb_d     = wstrb_q;
    bvalid_d    = s_axi_bvalid & !s_axi_bready;
    bresp_d     = s_axi_bresp;
    ctrl_shdn_d = ctrl_shdn_q;
    if (s_axi_awvalid && s_axi_awready) begin
      aw_full_d = 1'b1;
      awaddr_d  = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_full_d = 1'b1;
      wdata_d  = s_axi_wdata;
      wstrb_d  = s_axi_wstrb;
    end
    if (wr_do) begin
      aw_full_d = 1'b0;
      w_full_d  = 1'b0;
      bvalid_d  = 1'b1;
      bresp_d   = wr_hit ? AFPL_OKAY : AFPL_SLVERR;
      if (awaddr_q == ADDR_W'(`AFPL_OFF_CTRL) && wstrb_q[0])
        ctrl_shdn_d = wdata_q[`AFPL_CTRL_SHDN];
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      aw_full_q     <= 1'b0;
      w_full_q      <= 1'b0;
      awaddr_q      <= '0;
      wdata_q       <= '0;
      wstrb_q       <= '0;
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= AFPL_OKAY;
      ctrl_shdn_q   <= `AFPL_CTRL_RST;
    end else begin
      aw_full_q     <= aw_full_d;
      w_full_q      <= w_full_d;
      awaddr_q      <= awaddr_d;
      wdata_q       <= wdata_d;
      wstrb_q       <= wstrb_d;
      s_axi_awready <= !aw_full_d;
      s_axi_wready  <= !w_full_d;
      s_axi_bvalid  <= bvalid_d;
      s_axi_bresp   <= bresp_d;
      ctrl_shdn_q   <= ctrl_shdn_d;
    end
  end

  // ****************************************
  // AXI4-Lite read channel
  // ****************************************
  logic        arready_d;
  logic        rvalid_d;
  logic [31:0] rdata_d;
  afpl_resp_t  rresp_d;
  logic [31:0] status_w;
  logic [31:0] ctrl_w;

  always_comb begin
    status_w                   = '0;
    status_w[`AFPL_ST_OC]      = oc_q;
    status_w[`AFPL_ST_OT]      = ot_q;
    status_w[`AFPL_ST_DC]      = dc_q;
    status_w[`AFPL_ST_UV]      = uv_lvl;
    status_w[`AFPL_ST_OV]      = ov_lvl;
    status_w[`AFPL_ST_HIZ]     = outputs_hiz;
    status_w[`AFPL_ST_RUN]     = amp_run;
    status_w[`AFPL_ST_LOWCUR]  = low_current;
    status_w[`AFPL_ST_FAULT_N] = fault_flag_out_n;
    ctrl_w                     = '0;
    ctrl_w[`AFPL_CTRL_SHDN]    = ctrl_shdn_q;
  end

  always_comb begin
    arready_d = s_axi_arready;
    rvalid_d  = s_axi_rvalid;
    rdata_d   = s_axi_rdata;
    rresp_d   = s_axi_rresp;
    if (s_axi_rvalid && s_axi_rready) begin
      rvalid_d  = 1'b0;
      arready_d = 1'b1;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      arready_d = 1'b0;
      rvalid_d  = 1'b1;
      if (s_axi_araddr == ADDR_W'(`AFPL_OFF_CTRL)) begin
        rdata_d = ctrl_w;
        rresp_d = AFPL_OKAY;
      end else if (s_axi_araddr == ADDR_W'(`AFPL_OFF_STATUS)) begin
        rdata_d = status_w;
        rresp_d = AFPL_OKAY;
      end else begin
        rdata_d = '0;
        rresp_d = AFPL_SLVERR;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= AFPL_OKAY;
    end else begin
      s_axi_arready <= arready_d;
      s_axi_rvalid  <= rvalid_d;
      s_axi_rdata   <= rdata_d;
      s_axi_rresp   <= rresp_d;
    end
  end

endmodule

// ---- tb/afpl_host.sv ----
`timescale 1ns/10ps
module afpl_host (
  input  wire logic fault_flag_out_n,
  input  wire logic loop_en,
  input  wire logic sd_req_n,
  output logic      shutdown_in_n,
  output logic      mute_req
);
  // ****************************************
  // Host side of the shutdown line
  // ****************************************
  // Loop mode wires the fault line straight back, which gives self recovery
  always_comb begin
    shutdown_in_n = loop_en ? fault_flag_out_n : sd_req_n;
  end
  // Inverted fault holds mute, so a restart onto a hard short stays high impedance
  always_comb begin
    mute_req = !fault_flag_out_n;
  end
endmodule

// ---- tb/afpl_top_sva.sv ----
`timescale 1ns/10ps
module afpl_top_sva #(
  parameter int NCH         = 2,
  parameter int STARTUP_CYC = 20,
  parameter int DC_CYC      = 30
) (
  input wire logic           sys_clk,
  input wire logic           rstn,
  input wire logic           overcurrent_det,
  input wire logic           overtemp_det,
  input wire logic           supply_under_det,
  input wire logic           supply_over_det,
  input wire logic [NCH-1:0] duty_over_pos,
  input wire logic [NCH-1:0] duty_over_neg,
  input wire logic           shutdown_in_n,
  input wire logic           fault_flag_out_n,
  input wire logic           outputs_hiz,
  input wire logic           amp_run,
  input wire logic           low_current,
  input wire logic           s_axi_wvalid
);
  // ****************************************
  // Helper counters
  // ****************************************
  // Bounds carry a few cycles of slack for the two-stage input synchronisers
  logic [5:0]  evt_hist_q;
  logic [31:0] go_cnt_q;
  logic [31:0] dc_cnt_q;
  logic        go_cond;
  logic        dc_cond;
  assign go_cond = shutdown_in_n && fault_flag_out_n && !low_current && !amp_run && !supply_under_det
                   && !supply_over_det;
  assign dc_cond = amp_run && duty_over_pos[0] && !duty_over_neg[0];
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      evt_hist_q <= '0;
      go_cnt_q   <= '0;
      dc_cnt_q   <= '0;
    end else begin
      evt_hist_q <= {evt_hist_q[4:0], overcurrent_det | overtemp_det};
      go_cnt_q   <= go_cond ? go_cnt_q + 32'h1 : '0;
      dc_cnt_q   <= dc_cond ? dc_cnt_q + 32'h1 : '0;
    end
  end
  // ****************************************
  // Properties
  // ****************************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  AST_OC_TRIP: assert property (overcurrent_det [*4] |-> ##[0:1] (!fault_flag_out_n && outputs_hiz && !amp_run))
    else $error("overcurrent did not trip");
  AST_OT_TRIP: assert property (overtemp_det [*4] |-> ##[0:1] (!fault_flag_out_n && outputs_hiz && !amp_run))
    else $error("overtemperature did not trip");
  AST_UV_HIZ: assert property (supply_under_det [*4] |-> ##[0:1] (outputs_hiz && !amp_run))
    else $error("undervoltage did not stop outputs");
  AST_OV_HIZ: assert property (supply_over_det [*4] |-> ##[0:1] (outputs_hiz && !amp_run))
    else $error("overvoltage did not stop outputs");
  AST_FAULT_CAUSE: assert property ($fell(fault_flag_out_n) |-> (|evt_hist_q) || $past(amp_run))
    else $error("fault output fell without a reportable cause");
  AST_SD_CLEARS: assert property ((!shutdown_in_n && !overcurrent_det && !overtemp_det) [*6] |-> fault_flag_out_n)
    else $error("shutdown low did not clear latch");
  AST_LATCH_HOLD: assert property (((shutdown_in_n && !s_axi_wvalid) [*5] ##0 !fault_flag_out_n) |=> !fault_flag_out_n)
    else $error("latched fault released early");
  AST_SD_MUTE: assert property (!shutdown_in_n [*4] |-> ##[0:1] (low_current && outputs_hiz && !amp_run))
    else $error("shutdown low did not mute");
  AST_RUN_CLEAN: assert property (amp_run |-> (!outputs_hiz && fault_flag_out_n && !low_current))
    else $error("running with outputs stopped");
  AST_START_MIN: assert property ($rose(amp_run) |-> go_cnt_q >= STARTUP_CYC - 2)
    else $error("start-up too short");
  AST_START_MAX: assert property (go_cnt_q == STARTUP_CYC + 8 |-> amp_run)
    else $error("start-up too long");
  AST_DC_LIMIT: assert property (dc_cnt_q <= DC_CYC + 8)
    else $error("dc offset not caught in time");
endmodule

bind afpl_top afpl_top_sva #(.NCH(NCH), .STARTUP_CYC(STARTUP_CYC), .DC_CYC(DC_CYC)) i_sva (
  .sys_clk, .rstn, .overcurrent_det, .overtemp_det, .supply_under_det, .supply_over_det, .duty_over_pos,
  .duty_over_neg, .shutdown_in_n, .fault_flag_out_n, .outputs_hiz, .amp_run, .low_current, .s_axi_wvalid);

// ---- tb/afpl_top_tb.sv ----
`timescale 1ns/10ps
module afpl_top_tb;
  import afpl_pkg::*;
  localparam int SUC = 20;
  localparam int DCC = 30;
  logic        sys_clk, rstn, overcurrent_det, overtemp_det, supply_under_det, supply_over_det;
  logic        shutdown_in_n, fault_flag_out_n, outputs_hiz, amp_run, low_current, loop_en, sd_req_n;
  logic        mute_req;
  logic [1:0]  duty_over_pos, duty_over_neg;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  afpl_resp_t  s_axi_bresp, s_axi_rresp;
  int          n_mismatch, total_checks;

  afpl_top #(.STARTUP_CYC(SUC), .DC_CYC(DCC)) i_dut (
    .sys_clk, .rstn, .overcurrent_det, .overtemp_det, .supply_under_det, .supply_over_det, .duty_over_pos,
    .duty_over_neg, .shutdown_in_n, .fault_flag_out_n, .outputs_hiz, .amp_run, .low_current, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready);
  afpl_host i_host (.fault_flag_out_n(fault_flag_out_n), .loop_en(loop_en), .sd_req_n(sd_req_n),
    .shutdown_in_n(shutdown_in_n), .mute_req(mute_req));

  always #2 sys_clk = ~sys_clk;

  // ****************************************
  // Access tasks
  // ****************************************
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input afpl_resp_t er);
    @(posedge sys_clk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid  <= 1'h1;
    s_axi_bready  <= 1'h1;
    do begin
      @(posedge sys_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'h0;
    chk("bresp", {30'h0, s_axi_bresp}, {30'h0, er});
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [31:0] msk, input afpl_resp_t er);
    @(posedge sys_clk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready  <= 1'h1;
    do begin
      @(posedge sys_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'h0;
    chk("rdata", s_axi_rdata & msk, ed);
    chk("rresp", {30'h0, s_axi_rresp}, {30'h0, er});
  endtask
  // Low-current bit is masked: its level inside a latched fault is left open
  task automatic st(input logic [31:0] e);
    rd(8'h04, e, 32'h0000017F, AFPL_OKAY);
  endtask
  task automatic pins(input logic [2:0] e);
    chk("pins", {29'h0, fault_flag_out_n, outputs_hiz, amp_run}, {29'h0, e});
  endtask
  task automatic sd_pulse();
    @(posedge sys_clk) sd_req_n <= 1'h0;
    cyc(6);
    sd_req_n <= 1'h1;
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // ****************************************
  // Tests
  // ****************************************
  initial begin
    sys_clk = 1'h0;
    rstn = 1'h0;
    {overcurrent_det, overtemp_det, supply_under_det, supply_over_det, loop_en, sd_req_n} = '0;
    {duty_over_pos, duty_over_neg, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    s_axi_wstrb = 4'hF;
    n_mismatch = 0;
    total_checks = 0;
    cyc(11);
    pins(3'b110);
    @(posedge sys_clk) rstn <= 1'h1;
    rd(8'h00, 32'h0, '1, AFPL_OKAY);
    rd(8'h04, 32'h1A0, '1, AFPL_OKAY);
    rd(8'h08, 32'h0, '1, AFPL_SLVERR);
    wr(8'h0C, 32'hFFFFFFFF, AFPL_SLVERR);
    wr(8'h04, 32'hFFFFFFFF, AFPL_OKAY);
    rd(8'h04, 32'h1A0, '1, AFPL_OKAY);
    @(posedge sys_clk) sd_req_n <= 1'h1;
    cyc(SUC - 2);
    pins(3'b110);
    cyc(12);
    pins(3'b101);
    for (int i = 0; i < 2; i++) begin
      @(posedge sys_clk) {overtemp_det, overcurrent_det} <= 2'h1 << i;
      cyc(6);
      pins(3'b010);
      chk("mute", {31'h0, mute_req}, 32'h1);
      if (i == 1) sd_pulse();
      if (i == 1) st(32'h022);
      @(posedge sys_clk) {overtemp_det, overcurrent_det} <= 2'h0;
      cyc(10);
      st(32'h020 | (32'h1 << i));
      if (i == 0) sd_pulse();
      else wr(8'h00, 32'h2, AFPL_OKAY);
      cyc(SUC + 12);
      st(32'h140);
    end
    @(posedge sys_clk) duty_over_pos <= 2'h1;
    cyc(DCC - 4);
    {duty_over_pos, duty_over_neg} <= 4'h1;
    cyc(DCC - 4);
    duty_over_neg <= 2'h0;
    cyc(10);
    st(32'h140);
    duty_over_neg <= 2'h2;
    cyc(DCC + 12);
    pins(3'b010);
    duty_over_neg <= 2'h0;
    st(32'h024);
    @(posedge sys_clk) loop_en <= 1'h1;
    cyc(SUC + 16);
    pins(3'b101);
    chk("mute", {31'h0, mute_req}, 32'h0);
    loop_en <= 1'h0;
    for (int i = 0; i < 2; i++) begin
      @(posedge sys_clk) {supply_over_det, supply_under_det} <= 2'h1 << i;
      cyc(8);
      pins(3'b110);
      st(32'h120 | (32'h8 << i));
      {supply_over_det, supply_under_det} <= 2'h0;
      cyc(SUC + 12);
      st(32'h140);
    end
    wr(8'h00, 32'h1, AFPL_OKAY);
    rd(8'h00, 32'h1, '1, AFPL_OKAY);
    rd(8'h04, 32'h1A0, '1, AFPL_OKAY);
    wr(8'h00, 32'h0, AFPL_OKAY);
    cyc(SUC + 12);
    pins(3'b101);
    stop_test();
  end

  initial begin
    repeat (20000) @(posedge sys_clk);
    n_mismatch++;
    stop_test();
  end
endmodule
